// *** design/sbs_consts.svh ***
/*
 Constants for the synchronous burst memory interface: widths, lanes, burst length, timing.
 Assumes inclusion by bare name from design files.
*/
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
`define SBS_ADDR_W 18
`define SBS_DATA_W 36
`define SBS_LANES 4
`define SBS_BURST_LEN 4
`define SBS_CLK_PERIOD_PS 4000
`define SBS_FIRST_WORD_CYC 2
`endif

// *** design/sbs_pkg.sv ***
/*
 Types for the synchronous burst memory interface.
 Assumes nothing of its surroundings.
*/
package sbs_pkg;
   typedef enum logic [1:0] {
      SBS_IDLE = 2'b00,
      SBS_READ = 2'b01,
      SBS_WRITE = 2'b10
   } sbs_state_t;
   typedef enum logic {
      SBS_LINEAR = 1'b0,
      SBS_INTERLEAVED = 1'b1
   } sbs_order_t;
endpackage

// *** design/sbs_sram.sv ***
/*
 Synchronous flow-through burst memory with a two-bit burst counter and a two-entry
 read buffer. Assumes a memory controller on core_clk driving the synchronous inputs;
 output enable and sleep arrive from pins and are synchronised here.
*/
// Functional notes
// - Every synchronous input is sampled on the rising edge of the clock.
// - A two-bit burst counter loads the start address and generates the following ones.
// - Burst order select high steps interleaved, low steps linear.
// - Either address strobe alone starts a new burst.
// - On a strobe edge the address and chip selects are captured.
// - Following addresses are generated internally, stepped by the advance input.
// - Output enable and sleep pass through clocked pin synchronisers and then gate the data drive.
// - Bursts run 2-1-1-1: first word after two cycles, then one per cycle.
// - The array holds 256K words of 36 bits with separate data_in and data_out ports.
`include "sbs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sbs_sram #(
   parameter int ADDR_W = `SBS_ADDR_W,
   parameter int DATA_W = `SBS_DATA_W,
   parameter int LANES = `SBS_LANES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic chip_sel_pipe_n,
   input wire logic chip_sel_depth_hi,
   input wire logic chip_sel_depth_lo_n,
   input wire logic [LANES-1:0] lane_write_en_n,
   input wire logic lane_write_master_n,
   input wire logic all_lane_write_n,
   input wire logic burst_order,
   input wire logic out_enable_n,
   input wire logic sleep_request,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic buf_ready
);
   localparam int LANE_W = DATA_W / LANES;
   localparam int DEPTH = 1 << ADDR_W;

   // ----------------------------------------------------------------
   // Input registers
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] addr_q;
   logic ps_n_q, cs_n_q, adv_n_q, ce1_n_q, ce2_q, ce3_n_q, bwe_n_q, gw_n_q, mode_q;
   logic [LANES-1:0] bw_n_q;
   logic [DATA_W-1:0] din_q;
   // Second stage lines write data and enables up with the burst state
   logic [DATA_W-1:0] din2_q;
   logic [LANES-1:0] bw2_n_q;
   logic bwe2_n_q, gw2_n_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_q <= '0;
         ps_n_q <= 1'b1;
         cs_n_q <= 1'b1;
         adv_n_q <= 1'b1;
         ce1_n_q <= 1'b1;
         ce2_q <= 1'b0;
         ce3_n_q <= 1'b1;
         bw_n_q <= '1;
         bwe_n_q <= 1'b1;
         gw_n_q <= 1'b1;
         mode_q <= 1'b0;
         din_q <= '0;
         din2_q <= '0;
         bw2_n_q <= '1;
         bwe2_n_q <= 1'b1;
         gw2_n_q <= 1'b1;
      end else begin
         addr_q <= addr;
         ps_n_q <= proc_addr_strobe_n;
         cs_n_q <= ctrl_addr_strobe_n;
         adv_n_q <= burst_advance_n;
         ce1_n_q <= chip_sel_pipe_n;
         ce2_q <= chip_sel_depth_hi;
         ce3_n_q <= chip_sel_depth_lo_n;
         bw_n_q <= lane_write_en_n;
         bwe_n_q <= lane_write_master_n;
         gw_n_q <= all_lane_write_n;
         mode_q <= burst_order;
         din_q <= data_in;
         din2_q <= din_q;
         bw2_n_q <= bw_n_q;
         bwe2_n_q <= bwe_n_q;
         gw2_n_q <= gw_n_q;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers for output enable and sleep
   // ----------------------------------------------------------------
   logic [2:0] oe_sync_q, zz_sync_q;
   logic oe_n_q, zz_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         oe_sync_q <= 3'b111;
         zz_sync_q <= 3'b000;
         oe_n_q <= 1'b1;
         zz_q <= 1'b0;
      end else begin
         oe_sync_q <= {oe_sync_q[1:0], out_enable_n};
         zz_sync_q <= {zz_sync_q[1:0], sleep_request};
         if (oe_sync_q[2] == oe_sync_q[1]) begin
            oe_n_q <= oe_sync_q[2];
         end
         if (zz_sync_q[2] == zz_sync_q[1]) begin
            zz_q <= zz_sync_q[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Burst control
   // ----------------------------------------------------------------
   logic strobe, selected, wr_req, wr2_req, issue_q;
   logic [ADDR_W-1:0] base_q;
   logic [1:0] cnt_q, low_bits;
   logic burst_on_q, is_wr_q, sel_q;
   sbs_pkg::sbs_state_t state_q;
   assign strobe = !ps_n_q || !cs_n_q;
   assign selected = !ce1_n_q && ce2_q && !ce3_n_q;
   assign wr_req = !gw_n_q || (!bwe_n_q && !(&bw_n_q));
   assign wr2_req = !gw2_n_q || (!bwe2_n_q && !(&bw2_n_q));
   assign low_bits = (mode_q == sbs_pkg::SBS_INTERLEAVED)
      ? (base_q[1:0] ^ cnt_q) : (base_q[1:0] + cnt_q);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         base_q <= '0;
         cnt_q <= 2'b00;
         sel_q <= 1'b0;
         issue_q <= 1'b0;
         state_q <= sbs_pkg::SBS_IDLE;
      end else if (zz_q) begin
         issue_q <= 1'b0;
         state_q <= sbs_pkg::SBS_IDLE;
      end else if (strobe && buf_ready) begin
         base_q <= addr_q;
         sel_q <= selected;
         cnt_q <= 2'b00;
         if (!selected) begin
            issue_q <= 1'b0;
            state_q <= sbs_pkg::SBS_IDLE;
         end else if (!ps_n_q || !wr_req) begin
            issue_q <= 1'b1;
            state_q <= sbs_pkg::SBS_READ;
         end else begin
            issue_q <= 1'b0;
            state_q <= sbs_pkg::SBS_WRITE;
         end
      end else if (state_q != sbs_pkg::SBS_IDLE && !adv_n_q && buf_ready) begin
         cnt_q <= cnt_q + 2'b01;
         issue_q <= !wr_req;
         state_q <= wr_req ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
      end else if (buf_ready) begin
         // One read word per start or advance
         issue_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Memory array with byte lanes
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] cur_addr;
   logic do_write;
   wire logic [DATA_W-1:0] rd_word;
   assign cur_addr = {base_q[ADDR_W-1:2], low_bits};
   assign do_write = (state_q == sbs_pkg::SBS_WRITE) && wr2_req && sel_q && !zz_q;
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_W-1:0] mem_l [DEPTH];
         always_ff @(posedge core_clk) begin
            if (do_write && (!gw2_n_q || (!bwe2_n_q && !bw2_n_q[g]))) begin
               mem_l[cur_addr] <= din2_q[g*LANE_W +: LANE_W];
            end
         end
         assign rd_word[g*LANE_W +: LANE_W] = mem_l[cur_addr];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Two-entry read buffer
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] ent_q [2];
   logic [1:0] vld_q;
   logic wr_ptr_q, rd_ptr_q, push, pop;
   assign push = issue_q && (state_q == sbs_pkg::SBS_READ) && sel_q && !zz_q && buf_ready;
   assign pop = rd_valid && rd_ready;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         vld_q <= 2'b00;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         ent_q[0] <= '0;
         ent_q[1] <= '0;
      end else begin
         if (push) begin
            ent_q[wr_ptr_q] <= rd_word;
            wr_ptr_q <= !wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= !rd_ptr_q;
         end
         if (push) begin
            vld_q[wr_ptr_q] <= 1'b1;
         end
         if (pop && !(push && wr_ptr_q == rd_ptr_q)) begin
            vld_q[rd_ptr_q] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   logic [1:0] vld_n;
   logic rd_n;
   always_comb begin
      vld_n = vld_q;
      if (push) begin
         vld_n[wr_ptr_q] = 1'b1;
      end
      if (pop) begin
         vld_n[rd_ptr_q] = 1'b0;
      end
      rd_n = pop ? !rd_ptr_q : rd_ptr_q;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         data_out <= '0;
         data_oe <= 1'b0;
         rd_valid <= 1'b0;
         buf_ready <= 1'b1;
      end else begin
         rd_valid <= vld_n[rd_n];
         data_out <= (push && !vld_q[rd_n] && wr_ptr_q == rd_n) ? rd_word
            : ent_q[rd_n];
         data_oe <= !oe_n_q && !zz_q && vld_n[rd_n];
         buf_ready <= !(&vld_n);
      end
   end
endmodule // sbs_sram
`default_nettype wire

// *** verif/sbs_sram_asserts.sv ***
/* Port assertions for sbs_sram.
 Assumes one core_clk domain and a bind by port name. */
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_asserts #(
   parameter int DATA_W = 36
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic proc_addr_strobe_n,
   input wire logic out_enable_n,
   input wire logic sleep_request,
   input wire logic rd_ready,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe,
   input wire logic rd_valid,
   input wire logic buf_ready
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_reset_quiet: assert property (disable iff (1'h0)
      !rst_n |=> !rd_valid && !data_oe && buf_ready) else $error("reset left outputs set");
   a_read_latency: assert property (!proc_addr_strobe_n && buf_ready && !sleep_request
      |-> ##3 rd_valid) else $error("read word late");
   a_hold_stall: assert property (rd_valid && !rd_ready
      |=> rd_valid && $stable(data_out)) else $error("stalled word lost");
   a_oe_off: assert property (out_enable_n [*6] |-> !data_oe)
      else $error("data driven while disabled");
   a_oe_on: assert property ((!out_enable_n) [*6] ##0 rd_valid |-> data_oe)
      else $error("data not driven");
   a_start_idle: assert property ($rose(rst_n) |-> (!rd_valid) [*2])
      else $error("word after reset");
   a_sleep_idle: assert property (sleep_request [*8] ##0 !rd_valid |=> !rd_valid)
      else $error("word during sleep");
   a_full_pending: assert property (!buf_ready |-> rd_valid)
      else $error("full with no word");
endmodule // sbs_sram_asserts
bind sbs_sram sbs_sram_asserts #(.DATA_W(DATA_W)) chk_u (.*);
`default_nettype wire

// *** verif/sbs_sink.sv ***
/* Read sink on the controller side of the data path.
 Assumes core_clk and the design's read handshake. */
`timescale 1ns/1ps
`default_nettype none
module sbs_sink (
   input wire logic core_clk,
   input wire logic stall,
   input wire logic rd_valid,
   input wire logic [35:0] data_out,
   output logic rd_ready = 1'h1
);
   logic [35:0] got[$];
   always @(posedge core_clk) begin
      if (rd_valid && rd_ready) got.push_back(data_out);
      rd_ready <= !stall;
   end
endmodule // sbs_sink
`default_nettype wire

// *** verif/tb.sv ***
/* Self-checking bench for sbs_sram.
 Assumes the design files and sbs_sink are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; \
   if ((a) !== (b)) begin n_errors++; $display("FAIL %0t %h %h", $time, (a), (b)); end end
module tb;
   logic core_clk = 1'h0, rst_n = 1'h0, proc_addr_strobe_n = 1'h1, ctrl_addr_strobe_n = 1'h1;
   logic burst_advance_n = 1'h1, chip_sel_pipe_n = 1'h0, chip_sel_depth_hi = 1'h1;
   logic chip_sel_depth_lo_n = 1'h0, lane_write_master_n = 1'h1, all_lane_write_n = 1'h1;
   logic burst_order = 1'h0, out_enable_n = 1'h0, sleep_request = 1'h0, stall = 1'h0;
   logic data_oe, rd_valid, rd_ready, buf_ready;
   logic [3:0] lane_write_en_n = 4'hf;
   logic [17:0] addr = 18'h0_0000;
   logic [35:0] data_in = 36'h0_0000_0000, data_out;
   localparam logic [35:0] w_d = 36'h1_2345_6780, w_e = 36'hf_0f0f_0f00;
   int n_errors = 0, check_count = 0, cyc = 0;
   sbs_sram dut_u (.*);
   sbs_sink sink_u (.core_clk(core_clk), .stall(stall), .rd_valid(rd_valid),
      .data_out(data_out), .rd_ready(rd_ready));
   initial forever #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         results();
      end
   end
   function automatic logic [35:0] mix(int k);
      return {36'(w_d + 36'((k + 3) % 4)) >> 9, 9'(w_e + 36'((k + 3) % 4))};
   endfunction
   task automatic burst_wr(logic [35:0] d, logic [3:0] ln, logic g_n);
      @(posedge core_clk);
      addr <= 18'h0_0101;
      ctrl_addr_strobe_n <= 1'h0;
      lane_write_en_n <= ln;
      lane_write_master_n <= ~g_n;
      all_lane_write_n <= g_n;
      for (int i = 0; i < 4; i++) begin
         data_in <= d + 36'(i);
         @(posedge core_clk);
         ctrl_addr_strobe_n <= 1'h1;
         burst_advance_n <= 1'(i == 3);
      end
      all_lane_write_n <= 1'h1;
      lane_write_en_n <= 4'hf;
      lane_write_master_n <= 1'h1;
   endtask
   task automatic rd(logic [17:0] a, logic ctl, logic ord, int n);
      @(posedge core_clk);
      sink_u.got.delete();
      addr <= a;
      burst_order <= ord;
      ctrl_addr_strobe_n <= ~ctl;
      proc_addr_strobe_n <= ctl;
      for (int i = 1; i <= n; i++) begin
         @(posedge core_clk);
         ctrl_addr_strobe_n <= 1'h1;
         proc_addr_strobe_n <= 1'h1;
         burst_advance_n <= 1'(i == n);
      end
      for (int i = 0; i < 40 && sink_u.got.size() < n; i++) @(posedge core_clk);
   endtask
   task automatic results();
      $display("mismatches %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge core_clk);
      burst_wr(w_d, 4'hf, 1'h0);
      rd(18'h0_0101, 1'h1, sbs_pkg::SBS_LINEAR, 4);
      for (int i = 0; i < 4; i++) `CHK(sink_u.got[i], 36'(w_d + 36'(i)))
      burst_wr(w_e, 4'he, 1'h1);
      rd(18'h0_0101, 1'h0, sbs_pkg::SBS_INTERLEAVED, 4);
      for (int i = 0; i < 4; i++) `CHK(sink_u.got[i], mix(1 ^ i))
      stall <= 1'h1;
      rd(18'h0_0101, 1'h0, sbs_pkg::SBS_LINEAR, 1);
      rd(18'h0_0103, 1'h0, sbs_pkg::SBS_LINEAR, 1);
      @(negedge core_clk);
      `CHK({buf_ready, rd_valid, data_oe}, 3'h3)
      @(posedge core_clk);
      out_enable_n <= 1'h1;
      rd(18'h0_0100, 1'h0, sbs_pkg::SBS_LINEAR, 1);
      @(negedge core_clk);
      `CHK({rd_valid, data_oe, data_out}, {2'h2, mix(1)})
      @(posedge core_clk);
      out_enable_n <= 1'h0;
      stall <= 1'h0;
      repeat (20) @(posedge core_clk);
      `CHK({sink_u.got[0], sink_u.got[1], 32'(sink_u.got.size())}, {mix(1), mix(3), 32'h2})
      sleep_request <= 1'h1;
      repeat (6) @(posedge core_clk);
      rd(18'h0_0101, 1'h0, sbs_pkg::SBS_LINEAR, 1);
      `CHK(32'(sink_u.got.size()), 32'h0)
      results();
   end
endmodule // tb
`default_nettype wire
